//--- core/corner_pkg.sv
package corner_pkg;

  // code and corner frequency mapping
  localparam int CODE_W = 5;
  localparam logic [4:0] CODE_RESET = 5'h00;
  localparam logic [4:0] CODE_TOP = 5'h1D;
  localparam logic [4:0] MHZ_STEP_BASE = 5'h01;
  localparam logic [4:0] MHZ_TOP = 5'h1E;

  // frame shape: one command bit then the code bits
  localparam logic CMD_WRITE = 1'b1;
  localparam logic CMD_READ = 1'b0;
  localparam logic [2:0] CNT_IDLE = 3'h0;
  localparam logic [2:0] CNT_FIRST_BIT = 3'h1;
  localparam logic [2:0] CNT_LAST_BIT = 3'h5;
  localparam logic [2:0] CNT_DONE = 3'h6;

  // controller timing at the 20 MHz system clock
  localparam int MCLK_PERIOD_NS = 50;
  localparam int SCLK_HALF_NS = 200;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam logic [3:0] SCLK_HALF_LAST = 4'(SCLK_HALF_CYC - 1);

  // controller register map
  localparam int ADDR_W = 4;
  localparam logic [3:0] OFS_WRITE_CODE = 4'h0;
  localparam logic [3:0] OFS_START_READ = 4'h4;
  localparam logic [3:0] OFS_STATUS = 4'h8;
  localparam logic [3:0] OFS_READ_CODE = 4'hC;
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_DONE_BIT = 1;
  localparam int STATUS_LAST_WR_BIT = 2;

  typedef enum logic [2:0] {
    CST_IDLE = 3'b000,
    CST_SETUP = 3'b001,
    CST_BITS = 3'b010,
    CST_HOLD = 3'b011,
    CST_END = 3'b100
  } ctl_state_t;

endpackage : corner_pkg

//--- core/filter_port_if.sv
`timescale 1ns/1ps
interface filter_port_if;
  logic latch_strobe_n;
  logic serial_clk;
  logic serial_data;
  logic serial_readback_out;

  modport device (
    input latch_strobe_n,
    input serial_clk,
    input serial_data,
    output serial_readback_out
  );

  modport controller (
    output latch_strobe_n,
    output serial_clk,
    output serial_data,
    input serial_readback_out
  );
endinterface : filter_port_if

//--- core/bit_sync.sv
`timescale 1ns/1ps
module bit_sync (
  // clock and reset
  input wire logic mclk_i,
  input wire logic nrst_i,
  // level in and out
  input wire logic async_i,
  output logic sync_o
);
  logic meta_ff;
  logic sync_ff;

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
    end
  end

  assign sync_o = sync_ff;
endmodule : bit_sync

//--- core/corner_device.sv
`timescale 1ns/1ps
module corner_device (
  // reset of the device
  input wire logic nrst_i,
  // serial pins
  filter_port_if.device port,
  // filter side
  output logic [4:0] corner_code_o,
  output logic [4:0] corner_mhz_o
);
  // frame state lives on the serial clock; count, command and readback clear while strobe is high, the shifted code and ready mark do not
  logic frame_clr_n;
  logic [2:0] cnt_ff;
  logic [2:0] nxt_cnt;
  logic mode_wr_ff;
  logic [4:0] shift_ff;
  logic [4:0] nxt_shift;
  logic shifted_ff;
  logic nxt_shifted;
  logic [4:0] code_ff;
  logic [4:0] mhz_ff;
  logic [4:0] nxt_mhz;
  logic rb_ff;
  logic nxt_rb;
  logic in_bits;
  logic cmd_edge;
  logic [2:0] bit_idx;

  assign frame_clr_n = nrst_i & ~port.latch_strobe_n;
  assign cmd_edge = (cnt_ff == corner_pkg::CNT_IDLE);
  assign in_bits = (cnt_ff >= corner_pkg::CNT_FIRST_BIT) && (cnt_ff <= corner_pkg::CNT_LAST_BIT);
  assign bit_idx = cnt_ff - corner_pkg::CNT_FIRST_BIT;

  // edge counter stops after the last code bit
  assign nxt_cnt = (cnt_ff == corner_pkg::CNT_DONE) ? cnt_ff : cnt_ff + 3'h1;

  always_comb begin
    nxt_shift = shift_ff;
    if (in_bits && mode_wr_ff) begin
      nxt_shift[bit_idx] = port.serial_data;
    end
  end

  // a full code is marked ready; a new command bit withdraws it
  always_comb begin
    nxt_shifted = shifted_ff;
    if (cmd_edge) begin
      nxt_shifted = 1'b0;
    end else if (mode_wr_ff && (cnt_ff == corner_pkg::CNT_LAST_BIT)) begin
      nxt_shifted = 1'b1;
    end
  end

  always_ff @(posedge port.serial_clk or negedge frame_clr_n) begin
    if (!frame_clr_n) begin
      cnt_ff <= corner_pkg::CNT_IDLE;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  always_ff @(posedge port.serial_clk or negedge frame_clr_n) begin
    if (!frame_clr_n) begin
      mode_wr_ff <= corner_pkg::CMD_READ;
    end else if (cmd_edge) begin
      mode_wr_ff <= port.serial_data;
    end
  end

  always_ff @(posedge port.serial_clk or negedge nrst_i) begin
    if (!nrst_i) begin
      shift_ff <= corner_pkg::CODE_RESET;
      shifted_ff <= 1'b0;
    end else begin
      shift_ff <= nxt_shift;
      shifted_ff <= nxt_shifted;
    end
  end

  // saturating code to corner frequency in MHz
  assign nxt_mhz = (shift_ff >= corner_pkg::CODE_TOP) ? corner_pkg::MHZ_TOP
                   : shift_ff + corner_pkg::MHZ_STEP_BASE;

  // strobe rising edge commits a complete write; reads and partial writes leave it alone
  always_ff @(posedge port.latch_strobe_n or negedge nrst_i) begin
    if (!nrst_i) begin
      code_ff <= corner_pkg::CODE_RESET;
      mhz_ff <= corner_pkg::MHZ_STEP_BASE;
    end else if (shifted_ff) begin
      code_ff <= shift_ff;
      mhz_ff <= nxt_mhz;
    end
  end

  // readback presents the stored code on falling edges
  assign nxt_rb = (in_bits && !mode_wr_ff) ? code_ff[bit_idx] : 1'b0;

  always_ff @(negedge port.serial_clk or negedge frame_clr_n) begin
    if (!frame_clr_n) begin
      rb_ff <= 1'b0;
    end else begin
      rb_ff <= nxt_rb;
    end
  end

  assign port.serial_readback_out = rb_ff;
  assign corner_code_o = code_ff;
  assign corner_mhz_o = mhz_ff;
endmodule : corner_device

//--- core/corner_controller.sv
`timescale 1ns/1ps
module corner_controller (
  // clock and reset
  input wire logic mclk_i,
  input wire logic nrst_i,
  // register port
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // serial pins
  filter_port_if.controller port
);
  corner_pkg::ctl_state_t state_ff;
  corner_pkg::ctl_state_t nxt_state;
  logic [3:0] div_ff;
  logic tick;
  logic [2:0] bit_ff;
  logic sclk_ff;
  logic strobe_n_ff;
  logic data_ff;
  logic wr_mode_ff;
  logic [4:0] wcode_ff;
  logic [4:0] rcode_ff;
  logic done_ff;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic rb_sync;
  logic idle;
  logic start_wr;
  logic start_rd;
  logic [5:0] frame_bits;
  logic [2:0] code_idx;

  bit_sync u_rb_sync (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .async_i(port.serial_readback_out),
    .sync_o(rb_sync)
  );

  assign idle = (state_ff == corner_pkg::CST_IDLE);
  assign start_wr = wr_i && idle && (addr_i == corner_pkg::OFS_WRITE_CODE);
  assign start_rd = wr_i && idle && (addr_i == corner_pkg::OFS_START_READ);
  assign tick = (div_ff == corner_pkg::SCLK_HALF_LAST);
  assign frame_bits = {wcode_ff, wr_mode_ff};
  assign code_idx = bit_ff - 3'h1;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      corner_pkg::CST_IDLE: if (start_wr || start_rd) nxt_state = corner_pkg::CST_SETUP;
      corner_pkg::CST_SETUP: if (tick) nxt_state = corner_pkg::CST_BITS;
      corner_pkg::CST_BITS: begin
        if (tick && sclk_ff && bit_ff == corner_pkg::CNT_LAST_BIT) nxt_state = corner_pkg::CST_HOLD;
      end
      corner_pkg::CST_HOLD: if (tick) nxt_state = corner_pkg::CST_END;
      corner_pkg::CST_END: if (tick) nxt_state = corner_pkg::CST_IDLE;
      default: nxt_state = corner_pkg::CST_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_ff <= corner_pkg::CST_IDLE;
      div_ff <= 4'h0;
    end else begin
      state_ff <= nxt_state;
      div_ff <= (idle || tick) ? 4'h0 : div_ff + 4'h1;
    end
  end

  // pins: strobe low for the whole frame, data changes only while the clock is low
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      strobe_n_ff <= 1'b1;
      sclk_ff <= 1'b0;
      data_ff <= 1'b0;
      bit_ff <= 3'h0;
    end else if (start_wr || start_rd) begin
      strobe_n_ff <= 1'b0;
      data_ff <= start_wr ? corner_pkg::CMD_WRITE : corner_pkg::CMD_READ;
      bit_ff <= 3'h0;
    end else if (tick && state_ff == corner_pkg::CST_BITS) begin
      sclk_ff <= ~sclk_ff;
      if (sclk_ff) begin
        bit_ff <= bit_ff + 3'h1;
        data_ff <= (bit_ff == corner_pkg::CNT_LAST_BIT) ? 1'b0 : frame_bits[bit_ff + 3'h1];
      end
    end else if (tick && state_ff == corner_pkg::CST_HOLD) begin
      strobe_n_ff <= 1'b1;
    end
  end

  // command capture, readback sampling at each rising clock tick after the command bit
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_mode_ff <= 1'b0;
      wcode_ff <= corner_pkg::CODE_RESET;
      rcode_ff <= corner_pkg::CODE_RESET;
      done_ff <= 1'b0;
    end else begin
      if (start_wr) begin
        wr_mode_ff <= 1'b1;
        wcode_ff <= wdata_i[4:0];
      end else if (start_rd) begin
        wr_mode_ff <= 1'b0;
      end
      if (tick && state_ff == corner_pkg::CST_BITS && !sclk_ff && !wr_mode_ff && bit_ff != 3'h0) begin
        rcode_ff[code_idx] <= rb_sync;
      end
      if (tick && state_ff == corner_pkg::CST_END) begin
        done_ff <= 1'b1;
      end else if (start_wr || start_rd) begin
        done_ff <= 1'b0;
      end
    end
  end

  assign nxt_rdata = !rd_i ? 32'h0000_0000
    : (addr_i == corner_pkg::OFS_STATUS) ? {29'h0000_0000, wr_mode_ff, done_ff, ~idle}
    : (addr_i == corner_pkg::OFS_READ_CODE) ? {27'h0000_000, rcode_ff}
    : (addr_i == corner_pkg::OFS_WRITE_CODE) ? {27'h0000_000, wcode_ff}
    : 32'h0000_0000;

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_ff <= 32'h0000_0000;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign rdata_o = rdata_ff;
  assign port.latch_strobe_n = strobe_n_ff;
  assign port.serial_clk = sclk_ff;
  assign port.serial_data = data_ff;
endmodule : corner_controller

//--- verification/filter_corner_serial_port_sva.sv
`timescale 1ns/1ps
module filter_corner_serial_port_sva (
  // clock and reset
  input wire logic mclk_i,
  input wire logic nrst_i,
  // serial pins
  input wire logic latch_strobe_n,
  input wire logic serial_clk,
  input wire logic serial_data,
  input wire logic serial_readback_out,
  // filter side
  input wire logic [4:0] corner_code_o,
  input wire logic [4:0] corner_mhz_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  logic sclk_q_ff;
  logic wr_cmd_ff;
  logic [2:0] cnt_ff;
  logic [4:0] shift_ff;
  wire sclk_rise = serial_clk & ~sclk_q_ff;
  wire [4:0] top_mhz = (corner_code_o >= 5'h1D) ? 5'h1E : corner_code_o + 5'h01;
  // frame tracker: rises counted, command and code bits kept
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sclk_q_ff <= 1'b0;
      cnt_ff <= 3'h0;
      wr_cmd_ff <= 1'b0;
      shift_ff <= 5'h00;
    end else begin
      sclk_q_ff <= serial_clk;
      if (latch_strobe_n) cnt_ff <= 3'h0;
      else if (sclk_rise && cnt_ff != 3'h7) cnt_ff <= cnt_ff + 3'h1;
      if (!latch_strobe_n && sclk_rise && cnt_ff == 3'h0) wr_cmd_ff <= serial_data;
      if (!latch_strobe_n && sclk_rise && cnt_ff != 3'h0) shift_ff <= {serial_data, shift_ff[4:1]};
    end
  end
  AST_MHZ_MAP: assert property (corner_mhz_o == top_mhz)
    else $error("corner frequency does not follow code");
  AST_CODE_ONLY_AT_STROBE: assert property ($changed(corner_code_o) |-> $rose(latch_strobe_n))
    else $error("code changed while shifting");
  AST_WRITE_COMMIT: assert property ($rose(latch_strobe_n) && wr_cmd_ff |-> corner_code_o == shift_ff)
    else $error("committed code differs from shifted bits");
  AST_READ_KEEPS: assert property ($rose(latch_strobe_n) && !wr_cmd_ff |-> $stable(corner_code_o))
    else $error("read changed stored code");
  AST_READBACK_BIT: assert property (sclk_rise && !latch_strobe_n && !wr_cmd_ff && cnt_ff inside {[1:5]}
    |-> serial_readback_out == corner_code_o[cnt_ff - 3'h1])
    else $error("readback bit wrong");
  AST_READBACK_IDLE: assert property (latch_strobe_n |-> !serial_readback_out)
    else $error("readback active outside frame");
  AST_SCLK_IDLE: assert property (latch_strobe_n |-> !serial_clk)
    else $error("serial clock runs with strobe high");
  AST_STROBE_SETUP: assert property ($fell(latch_strobe_n) |-> !serial_clk [*4])
    else $error("serial clock too soon after strobe");
  AST_SCLK_HIGH: assert property ($rose(serial_clk) |-> serial_clk [*4] ##1 !serial_clk)
    else $error("serial clock high phase wrong");
  AST_DATA_STABLE: assert property ($rose(serial_clk) |-> $stable(serial_data))
    else $error("data moved at clock rise");
  AST_SIX_RISES: assert property ($rose(latch_strobe_n) |-> cnt_ff == 3'h6)
    else $error("frame clock count wrong");
endmodule : filter_corner_serial_port_sva

//--- verification/tb_filter_corner_serial_port.sv
`timescale 1ns/1ps
module tb_filter_corner_serial_port;
  logic mclk_i = 1'b0;
  logic nrst_i;
  logic [3:0] addr_i = 4'h0;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] rdata_o;
  logic [4:0] corner_code_o;
  logic [4:0] corner_mhz_o;
  int err_total = 0;
  int samples_checked = 0;
  filter_port_if port_if();
  corner_controller corner_controller_inst (.mclk_i(mclk_i), .nrst_i(nrst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .port(port_if.controller));
  corner_device corner_device_inst (.nrst_i(nrst_i), .port(port_if.device),
    .corner_code_o(corner_code_o), .corner_mhz_o(corner_mhz_o));
  filter_corner_serial_port_sva filter_corner_serial_port_sva_inst (.mclk_i(mclk_i), .nrst_i(nrst_i),
    .latch_strobe_n(port_if.latch_strobe_n), .serial_clk(port_if.serial_clk),
    .serial_data(port_if.serial_data), .serial_readback_out(port_if.serial_readback_out),
    .corner_code_o(corner_code_o), .corner_mhz_o(corner_mhz_o));
  initial begin
    forever #25 mclk_i = ~mclk_i;
  end
  function automatic logic [4:0] exp_mhz(input logic [4:0] c);
    return (c >= 5'h1D) ? 5'h1E : c + 5'h01;
  endfunction : exp_mhz
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", nm, exp, got);
      err_total++;
    end
  endtask : check
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask : reg_rd
  task automatic wait_idle();
    logic [31:0] s;
    for (int n = 0; n < 200; n++) begin
      reg_rd(corner_pkg::OFS_STATUS, s);
      if (s[corner_pkg::STATUS_BUSY_BIT] === 1'b0) return;
    end
    check("idle wait", 32'h0, s);
    report_and_stop();
  endtask : wait_idle
  initial begin
    logic [4:0] code;
    logic [31:0] d;
    // a real falling edge at time zero so every asynchronous reset branch runs
    nrst_i <= 1'b0;
    void'($urandom(32'hd19c));
    repeat (2) @(posedge mclk_i);
    nrst_i <= 1'b1;
    #1 check("reset code", 32'h0, {27'h0, corner_code_o});
    check("reset mhz", 32'h1, {27'h0, corner_mhz_o});
    reg_rd(4'h2, d);
    check("unmapped", 32'h0, d);
    for (int i = 0; i < 14; i++) begin
      code = (i == 0) ? 5'h1D : (i == 1) ? 5'h1E : (i == 2) ? 5'h1F : (i == 3) ? 5'h00 : 5'($urandom());
      reg_wr(corner_pkg::OFS_WRITE_CODE, {27'h0, code});
      // a start while busy is dropped
      reg_wr(corner_pkg::OFS_START_READ, 32'h0);
      wait_idle();
      check("code", {27'h0, code}, {27'h0, corner_code_o});
      check("mhz", {27'h0, exp_mhz(code)}, {27'h0, corner_mhz_o});
      reg_rd(corner_pkg::OFS_STATUS, d);
      check("status", 32'h6, d);
      @(posedge mclk_i);
      #1 check("rdata one cycle", 32'h0, rdata_o);
      reg_rd(corner_pkg::OFS_WRITE_CODE, d);
      check("write code reg", {27'h0, code}, d);
      reg_wr(corner_pkg::OFS_START_READ, 32'h0);
      wait_idle();
      reg_rd(corner_pkg::OFS_STATUS, d);
      check("status after read", 32'h2, d);
      reg_rd(corner_pkg::OFS_READ_CODE, d);
      check("readback", {27'h0, code}, d);
      check("code after read", {27'h0, code}, {27'h0, corner_code_o});
    end
    // reset in mid-run returns both ends to their defaults
    @(posedge mclk_i);
    nrst_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    nrst_i <= 1'b1;
    #1 check("reset code again", 32'h0, {27'h0, corner_code_o});
    check("reset mhz again", 32'h1, {27'h0, corner_mhz_o});
    reg_wr(corner_pkg::OFS_START_READ, 32'h0);
    wait_idle();
    reg_rd(corner_pkg::OFS_READ_CODE, d);
    check("readback after reset", 32'h0, d);
    report_and_stop();
  end
endmodule : tb_filter_corner_serial_port
